/* inc/fsl_pkg.sv */
package fsl_pkg;
	typedef enum logic [1:0] {fsl_unlock_type_v, fsl_soft_type_v, fsl_hard_type_v} fsl_lock_type;
	typedef enum logic [2:0]
	{
		fsl_cmd_none,
		fsl_cmd_chip_erase,
		fsl_cmd_block_erase,
		fsl_cmd_sector_erase,
		fsl_cmd_byte_program,
		fsl_cmd_byte_verify
	} fsl_cmd_type;
	typedef enum logic [1:0] {fsl_src_code_read, fsl_src_iap, fsl_src_host} fsl_src_type;
	typedef struct packed
	{
		logic valid;
		fsl_src_type source;
		fsl_cmd_type cmd;
		logic target_block;
		logic from_internal;
		logic from_block;
		logic [7:0] flash_data;
	} fsl_req_type;
endpackage

/* inc/fsl_regs.svh */
`ifndef FSL_REGS_SVH
`define FSL_REGS_SVH
`define FSL_STATUS_OFFSET 8'h00
`define FSL_CMD_OFFSET 8'h04
`define FSL_DATA_OFFSET 8'h08
`define FSL_LOCK_MSB 7
`define FSL_LOCK_LSB 5
`define FSL_LOCK_RESET 3'h0
`define FSL_CODE_READ_INSTRUCTION_BLOCKED 8'hff
`define FSL_HOST_BLOCKED 8'h00
`endif

/* rtl/fsl_lock.sv */
// Local design decisions: the address-and-strobe port and the register offsets.
`include "fsl_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module fsl_lock
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [2:0] lock_cells,
	input wire logic external_access_select_pin,
	input wire fsl_pkg::fsl_req_type req,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [7:0] reg_rdata,
	output logic grant,
	output logic deny,
	output logic [7:0] read_data,
	output logic boot_external
);
	logic [2:0] lock_status;
	logic load_pending;
	logic [2:0] pin_sync;
	logic [7:0] flash_data_reg;
	logic [2:0] flash_command_mailbox;
	fsl_pkg::fsl_lock_type lock0;
	fsl_pkg::fsl_lock_type lock1;
	logic verify_off;
	logic cross_ok;
	logic sec_only;
	logic allow;
	logic is_read;
	fsl_pkg::fsl_lock_type tgt;
	logic [7:0] next_read_data;

	// stored 0 = programmed, so invert cells into status bits
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			lock_status <= `FSL_LOCK_RESET;
			load_pending <= 1'b1;
		end
		else if (load_pending)
		begin
			lock_status <= ~lock_cells;
			load_pending <= 1'b0;
		end
	end

	// no reset here: the chain keeps filling with the pin during reset, so the
	// first agreement after release reflects the real pin, not a cleared stage
	always_ff @(posedge clk)
	begin
		pin_sync <= {pin_sync[1:0], external_access_select_pin};
	end

	// pin taken once the 2nd and 3rd stages agree, then frozen until reset, except at lock_status 0 where it keeps following the pin
	logic pin_latched;
	logic pin_done;
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			pin_latched <= 1'b0;
			pin_done <= 1'b0;
		end
		else if (!pin_done && !load_pending && pin_sync[1] == pin_sync[2])
		begin
			pin_latched <= pin_sync[2];
			pin_done <= (lock_status != 3'h0);
		end
	end

	// decode of level per block
	always_comb
	begin
		lock0 = fsl_pkg::fsl_unlock_type_v;
		lock1 = fsl_pkg::fsl_unlock_type_v;
		verify_off = 1'b0;
		cross_ok = 1'b0;
		sec_only = 1'b0;
		unique case (lock_status)
			3'h0:
			begin
				lock0 = fsl_pkg::fsl_unlock_type_v;
			end
			3'h4:
			begin
				lock0 = fsl_pkg::fsl_soft_type_v;
				lock1 = fsl_pkg::fsl_soft_type_v;
			end
			3'h3, 3'h5, 3'h7:
			begin
				lock0 = fsl_pkg::fsl_hard_type_v;
				lock1 = fsl_pkg::fsl_hard_type_v;
				verify_off = 1'b1;
			end
			3'h2:
			begin
				lock0 = fsl_pkg::fsl_soft_type_v;
				lock1 = fsl_pkg::fsl_soft_type_v;
				verify_off = 1'b1;
				cross_ok = 1'b1;
			end
			3'h6, 3'h1:
			begin
				lock0 = fsl_pkg::fsl_soft_type_v;
				lock1 = fsl_pkg::fsl_hard_type_v;
				verify_off = 1'b1;
				sec_only = 1'b1;
			end
		endcase
	end

	// access decision
	always_comb
	begin
		tgt = req.target_block ? lock1 : lock0;
		is_read = (req.cmd == fsl_pkg::fsl_cmd_none) || (req.cmd == fsl_pkg::fsl_cmd_byte_verify);
		allow = 1'b1;
		if (req.cmd == fsl_pkg::fsl_cmd_chip_erase)
			allow = 1'b1;
		else if (req.source == fsl_pkg::fsl_src_host)
			allow = (tgt == fsl_pkg::fsl_unlock_type_v);
		else if (req.source == fsl_pkg::fsl_src_code_read)
		begin
			if (!req.from_internal)
				allow = (tgt == fsl_pkg::fsl_unlock_type_v);
			else if (tgt == fsl_pkg::fsl_hard_type_v)
				allow = (req.from_block == req.target_block);
		end
		else if (tgt == fsl_pkg::fsl_hard_type_v)
			allow = 1'b0;
		else if (tgt == fsl_pkg::fsl_soft_type_v)
		begin
			// mailbox work on soft block only from code in a locked block
			allow = req.from_internal && ((req.from_block ? lock1 : lock0) != fsl_pkg::fsl_unlock_type_v);
			if (req.cmd == fsl_pkg::fsl_cmd_byte_verify && verify_off)
				allow = 1'b0;
			if (!is_read && lock_status == 3'h4)
				allow = 1'b0;
			if (sec_only && !(req.from_block && !req.target_block))
				allow = 1'b0;
			if (cross_ok && req.from_block == req.target_block)
				allow = allow && is_read;
		end
	end

	always_comb
	begin
		next_read_data = req.flash_data;
		if (!allow)
		begin
			unique case (req.source)
				fsl_pkg::fsl_src_host: next_read_data = `FSL_HOST_BLOCKED;
				fsl_pkg::fsl_src_iap: next_read_data = flash_data_reg;
				default: next_read_data = `FSL_CODE_READ_INSTRUCTION_BLOCKED;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			grant <= 1'b0;
			deny <= 1'b0;
			read_data <= 8'h00;
		end
		else
		begin
			grant <= req.valid && allow;
			deny <= req.valid && !allow;
			if (req.valid && is_read)
				read_data <= next_read_data;
		end
	end

	// iap data register keeps old content on blocked read
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			flash_data_reg <= 8'h00;
		else if (reg_write && reg_addr == `FSL_DATA_OFFSET)
			flash_data_reg <= reg_wdata;
		else if (req.valid && req.source == fsl_pkg::fsl_src_iap && is_read && allow)
			flash_data_reg <= req.flash_data;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			flash_command_mailbox <= 3'h0;
		else if (reg_write && reg_addr == `FSL_CMD_OFFSET)
			flash_command_mailbox <= reg_wdata[2:0];
	end

	// status writes are dropped: lock level only changes through reset
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			reg_rdata <= 8'h00;
		else if (reg_read)
		begin
			unique case (reg_addr)
				`FSL_STATUS_OFFSET: reg_rdata <= {lock_status, 5'h00};
				`FSL_CMD_OFFSET: reg_rdata <= {5'h00, flash_command_mailbox};
				`FSL_DATA_OFFSET: reg_rdata <= flash_data_reg;
				default: reg_rdata <= 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			boot_external <= 1'b0;
		else if (!load_pending)
			boot_external <= (lock_status != 3'h7) && !pin_latched;
	end
endmodule // fsl_lock
`default_nettype wire

/* testbench/fsl_cell_model.sv */
`timescale 1ns/100ps
`default_nettype none
module fsl_cell_model
(
	input wire logic [2:0] level,
	output logic [2:0] lock_cells
);
	// a programmed cell reads back 0
	assign lock_cells = ~level;
endmodule // fsl_cell_model
`default_nettype wire

/* testbench/fsl_lock_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
module fsl_lock_monitor
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [2:0] lock_cells,
	input wire fsl_pkg::fsl_req_type req,
	input wire logic [7:0] reg_addr,
	input wire logic reg_read,
	input wire logic [7:0] reg_rdata,
	input wire logic grant,
	input wire logic deny,
	input wire logic [7:0] read_data,
	input wire logic boot_external
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	property p_ans; req.valid |=> grant ^ deny; endproperty
	a_ans: assert property (p_ans) else $error("answer missing");
	property p_idle; !req.valid |=> !grant && !deny; endproperty
	a_idle: assert property (p_idle) else $error("answer unasked");
	property p_stat; reg_read && reg_addr == 8'h00 |=> reg_rdata == {~lock_cells, 5'h00}; endproperty
	a_stat: assert property (p_stat) else $error("status wrong");
	property p_open; lock_cells == 3'h7 && req.valid |=> grant; endproperty
	a_open: assert property (p_open) else $error("open level denied");
	property p_chip; req.valid && req.cmd == 3'h1 |=> grant; endproperty
	a_chip: assert property (p_chip) else $error("chip erase denied");
	// soft acts as hard for the host, so any lock refuses it everything but chip erase
	property p_host; req.valid && req.source == 2'h2 && req.cmd != 3'h1 && lock_cells != 3'h7 |=> deny; endproperty
	a_host: assert property (p_host) else $error("host not refused");
	property p_boot; lock_cells == 3'h0 |-> !boot_external; endproperty
	a_boot: assert property (p_boot) else $error("external boot at top level");
	property p_ff; req.valid && req.source == 2'h0 ##1 deny |-> read_data == 8'hff; endproperty
	a_ff: assert property (p_ff) else $error("blocked code read not ff");
	c_iap: cover property (req.valid && req.source == 2'h1);
	c_deny: cover property (deny);
	c_stat: cover property (reg_read);
endmodule // fsl_lock_monitor
bind fsl_lock fsl_lock_monitor u_fsl_lock_monitor (.*);
`default_nettype wire

/* testbench/test_fsl_lock.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin err_count++; $display("unexpected %0t %h %h", $time, a, e); end end
module test_fsl_lock;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [2:0] level = 3'h0;
	logic [2:0] lock_cells;
	logic pin = 1'b0;
	fsl_pkg::fsl_req_type req = '0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic [7:0] reg_rdata;
	logic grant;
	logic deny;
	logic [7:0] read_data;
	logic boot_external;
	int err_count = 0;
	int num_checks = 0;
	always #2 clk = ~clk;
	fsl_cell_model u_fsl_cell_model (.level(level), .lock_cells(lock_cells));
	fsl_lock u_fsl_lock (.clk(clk), .sys_rst(sys_rst), .lock_cells(lock_cells),
		.external_access_select_pin(pin), .req(req), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .grant(grant),
		.deny(deny), .read_data(read_data), .boot_external(boot_external));
	// cells are only sampled at reset, so every level change needs one
	task automatic restart(input logic [2:0] lv, input logic p);
		@(posedge clk);
		level <= lv;
		pin <= p;
		sys_rst <= 1'b1;
		repeat (12) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (8) @(posedge clk);
	endtask
	// tif is {target_block, from_internal, from_block}
	task automatic ask(input logic [1:0] s, input logic [2:0] c, input logic [2:0] tif, input logic g);
		@(posedge clk);
		req <= '{1'b1, fsl_pkg::fsl_src_type'(s), fsl_pkg::fsl_cmd_type'(c), tif[2], tif[1], tif[0], 8'h00};
		@(posedge clk);
		req <= '0;
		#1 `CHK({grant, deny}, {g, ~g})
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk);
		reg_read <= 1'b0;
		#1 `CHK(reg_rdata, e)
	endtask
	task automatic s_open;
		restart(3'h0, 1'b0);
		rd(8'h00, 8'h00);
		ask(2'h2, 3'h4, 3'h0, 1'b1);
		ask(2'h0, 3'h0, 3'h4, 1'b1);
		`CHK(boot_external, 1'b1)
	endtask
	task automatic s_soft;
		restart(3'h4, 1'b1);
		rd(8'h00, 8'h80);
		ask(2'h2, 3'h5, 3'h0, 1'b0);
		`CHK(read_data, 8'h00)
		ask(2'h0, 3'h0, 3'h0, 1'b0);
		`CHK(read_data, 8'hff)
		pin <= 1'b0;
		repeat (8) @(posedge clk);
		`CHK(boot_external, 1'b0)
	endtask
	task automatic s_hard(input logic [2:0] lv);
		restart(lv, 1'b0);
		@(posedge clk);
		reg_write <= 1'b1;
		@(posedge clk);
		reg_write <= 1'b0;
		rd(8'h00, {lv, 5'h00});
		ask(2'h2, 3'h2, 3'h4, 1'b0);
		ask(2'h1, 3'h5, 3'h6, 1'b0);
		ask(2'h0, 3'h0, 3'h4, 1'b0);
		ask(2'h2, 3'h1, 3'h0, 1'b1);
	endtask
	task automatic s_split(input logic [2:0] lv);
		restart(lv, 1'b0);
		ask(2'h1, 3'h4, 3'h3, 1'b1);
		ask(2'h1, 3'h3, 3'h3, 1'b1);
		ask(2'h0, 3'h0, 3'h6, 1'b0);
	endtask
	task automatic s_cross;
		restart(3'h2, 1'b0);
		ask(2'h1, 3'h4, 3'h3, 1'b1);
		ask(2'h1, 3'h4, 3'h6, 1'b1);
		ask(2'h2, 3'h5, 3'h0, 1'b0);
	endtask
	task automatic s_top;
		restart(3'h7, 1'b0);
		`CHK(boot_external, 1'b0)
		rd(8'h00, 8'he0);
		ask(2'h0, 3'h0, 3'h4, 1'b0);
	endtask
	task automatic print_verdict;
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial
	begin
		s_open();
		s_soft();
		s_hard(3'h3);
		s_hard(3'h5);
		s_split(3'h6);
		s_split(3'h1);
		s_cross();
		s_top();
		print_verdict();
	end
endmodule // test_fsl_lock
`default_nettype wire
